// file: lsc_defs.svh
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH
// Partition mode value for all-SRAM operation
`define LSC_MODE_ALL_SRAM 3'h0
// Cacheable flag position inside a memory attribute register
`define LSC_MAR_CE_BIT 0
// Memory attribute registers reset to not cacheable
`define LSC_MAR_RESET 1'h0
`endif

// file: lsc_pkg.sv
`default_nettype none
package lsc_pkg;
	// Requester of an SRAM transfer
	typedef enum logic [1:0] {
		LSC_SRC_DMA = 2'h0,
		LSC_SRC_HOST = 2'h1
	} lsc_src_t;
	// Transfer request from the DMA engine or host port
	typedef struct packed {
		logic valid;
		logic write;
		lsc_src_t src;
		logic [31:0] addr;
		logic [31:0] wdata;
	} lsc_xfer_t;
	// Snoop command towards a level-one cache
	typedef struct packed {
		logic valid;
		logic invalidate;
		logic [31:0] addr;
	} lsc_snoop_t;
	// Snoop answer from the level-one data cache
	typedef struct packed {
		logic valid;
		logic dirty;
		logic [31:0] data;
	} lsc_snoop_rsp_t;
	// Snooper states, Gray coded along the usual path
	typedef enum logic [1:0] {
		LSC_IDLE = 2'h0,
		LSC_SNOOP = 2'h1,
		LSC_MERGE = 2'h3,
		LSC_DONE = 2'h2
	} lsc_state_t;
endpackage
`default_nettype wire

// file: lsc_tag_copy.sv
`timescale 1ns/1ps
`default_nettype none
// Shadow copy of level-one data cache tags, one entry per set
module lsc_tag_copy #(
	parameter int SETS = 64,
	parameter int IDX_W = 6,
	parameter int TAG_W = 20
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic alloc,
	input wire logic [IDX_W-1:0] alloc_idx,
	input wire logic [TAG_W-1:0] alloc_tag,
	input wire logic inval,
	input wire logic [IDX_W-1:0] inval_idx,
	input wire logic [IDX_W-1:0] look_idx,
	input wire logic [TAG_W-1:0] look_tag,
	output logic hit
);
	logic [TAG_W-1:0] tag_q [SETS];
	logic [SETS-1:0] vld_q;
	logic [SETS-1:0] vld_d;
	// Allocation wins over an invalidation of the same set
	always_comb begin
		vld_d = vld_q;
		if (inval)
			vld_d[inval_idx] = 1'b0;
		if (alloc)
			vld_d[alloc_idx] = 1'b1;
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			vld_q <= '0;
		else
			vld_q <= vld_d;
		if (alloc)
			tag_q[alloc_idx] <= alloc_tag;
	end
	assign hit = vld_q[look_idx] && (tag_q[look_idx] == look_tag);
endmodule // lsc_tag_copy
`default_nettype wire

// file: lsc_snooper.sv
// Functional notes
// - Mode 000b makes all level-two memory SRAM
// - Non-cacheable access returns element, allocates nothing
// - Cacheable access allocates level-one data only
// - Host read copies dirty data back first
// - Host write snoops, writes back, invalidates
// - Control registers unreachable from DMA or host
// - No snooping of external memory space
// - DMA read stalls until data snoop responds
// - Variant keeps or invalidates line after read
// - Program cache never snooped on DMA read
// - DMA write snoops and invalidates program cache
// - DMA write invalidates data cache lines
// - Tag copy tracked, consulted for snoop need
// - CPU write miss to SRAM passes straight through
// - CPU access to filled SRAM allocates lines
// - Cacheable flags reset to not cacheable
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.svh"
module lsc_snooper #(
	parameter bit KEEP_AFTER_READ = 1'b1,
	parameter int SRAM_BYTES = 65536,
	parameter int MAR_N = 16,
	parameter int LINE_B = 5,
	parameter int SETS_B = 6
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] l2_partition_mode,
	input wire logic mar_we,
	input wire logic [$clog2(MAR_N)-1:0] mar_idx,
	input wire logic [31:0] mar_wdata,
	input wire lsc_pkg::lsc_xfer_t xfer_req,
	output logic xfer_ready,
	output logic xfer_done,
	output logic xfer_abort,
	output logic [31:0] xfer_rdata,
	output lsc_pkg::lsc_snoop_t dsnoop,
	input wire lsc_pkg::lsc_snoop_rsp_t dsnoop_rsp,
	output lsc_pkg::lsc_snoop_t psnoop,
	input wire logic cpu_valid,
	input wire logic cpu_write,
	input wire logic [31:0] cpu_addr,
	input wire logic cpu_l1_hit,
	output logic cpu_l1_alloc,
	output logic cpu_single,
	output logic cpu_to_sram,
	output logic sram_we,
	output logic [31:0] sram_addr,
	output logic [31:0] sram_wdata,
	input wire logic [31:0] sram_rdata
);
	import lsc_pkg::*;
	localparam int TAG_W = 32 - LINE_B - SETS_B;
	localparam int MAR_SH = 32 - $clog2(MAR_N);
	lsc_state_t st_q, st_d;
	lsc_xfer_t req_q, req_d;
	logic [31:0] rdata_q, rdata_d;
	logic [MAR_N-1:0] ce_q, ce_d;
	logic snoop_hit;
	logic all_sram, cpu_in_sram, cpu_ce, in_sram;
	logic tc_inval;
	// Address maps: SRAM from zero, external space beyond it
	assign all_sram = (l2_partition_mode == `LSC_MODE_ALL_SRAM);
	assign in_sram = (xfer_req.addr < 32'(SRAM_BYTES));
	assign cpu_in_sram = all_sram && (cpu_addr < 32'(SRAM_BYTES));
	assign cpu_ce = ce_q[cpu_addr[31:MAR_SH]];
	// CPU path: SRAM always cacheable, external by flag
	always_comb begin
		cpu_to_sram = cpu_valid && cpu_in_sram;
		cpu_single = cpu_valid && !cpu_in_sram && !cpu_ce;
		// Write miss to SRAM passes through without allocating
		cpu_l1_alloc = cpu_valid && !cpu_l1_hit && !(cpu_write && cpu_in_sram)
			&& (cpu_in_sram || cpu_ce);
	end
	// Cacheable flags, least significant bit of each attribute word
	always_comb begin
		ce_d = ce_q;
		if (mar_we)
			ce_d[mar_idx] = mar_wdata[`LSC_MAR_CE_BIT];
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			ce_q <= {MAR_N{`LSC_MAR_RESET}};
		else
			ce_q <= ce_d;
	end
	// Shadow tags; only SRAM lines are tracked, external space is never snooped
	lsc_tag_copy #(
		.SETS(1 << SETS_B),
		.IDX_W(SETS_B),
		.TAG_W(TAG_W)
	) u_tags (
		.clk(clk),
		.sys_rst(sys_rst),
		.alloc(cpu_l1_alloc && cpu_in_sram),
		.alloc_idx(cpu_addr[LINE_B +: SETS_B]),
		.alloc_tag(cpu_addr[31 -: TAG_W]),
		.inval(tc_inval),
		.inval_idx(req_q.addr[LINE_B +: SETS_B]),
		.look_idx(req_q.addr[LINE_B +: SETS_B]),
		.look_tag(req_q.addr[31 -: TAG_W]),
		.hit(snoop_hit)
	);
	// Transfers outside SRAM are refused; control space is never served
	assign xfer_ready = (st_q == LSC_IDLE);
	assign xfer_abort = xfer_req.valid && xfer_ready && !(all_sram && in_sram);
	// Snoop sequencer: on a tag copy hit, stalls the transfer until the data cache answers
	always_comb begin
		st_d = st_q;
		req_d = req_q;
		rdata_d = rdata_q;
		dsnoop = '0;
		psnoop = '0;
		sram_we = 1'b0;
		sram_addr = req_q.addr;
		sram_wdata = req_q.wdata;
		tc_inval = 1'b0;
		xfer_done = 1'b0;
		case (st_q)
			LSC_IDLE: begin
				if (xfer_req.valid && !xfer_abort) begin
					req_d = xfer_req;
					st_d = LSC_SNOOP;
				end
			end
			LSC_SNOOP: begin
				// DMA writes notify the program cache; host writes and all reads never
				psnoop.valid = req_q.write && (req_q.src == LSC_SRC_DMA);
				psnoop.invalidate = 1'b1;
				psnoop.addr = req_q.addr;
				if (!snoop_hit) begin
					st_d = LSC_MERGE;
				end else begin
					dsnoop.valid = 1'b1;
					dsnoop.addr = req_q.addr;
					// Host traffic and writes invalidate; DMA read per variant
					dsnoop.invalidate = req_q.write || (req_q.src == LSC_SRC_HOST)
						|| !KEEP_AFTER_READ;
					if (dsnoop_rsp.valid) begin
						tc_inval = dsnoop.invalidate;
						// Modified data lands in SRAM before the request goes on
						if (dsnoop_rsp.dirty) begin
							sram_we = 1'b1;
							sram_wdata = dsnoop_rsp.data;
						end
						st_d = LSC_MERGE;
					end
				end
			end
			LSC_MERGE: begin
				// Write overlays SRAM, read samples it, now coherent
				sram_we = req_q.write;
				rdata_d = sram_rdata;
				st_d = LSC_DONE;
			end
			default: begin
				xfer_done = 1'b1;
				st_d = LSC_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= LSC_IDLE;
			req_q <= '0;
			rdata_q <= '0;
		end else begin
			st_q <= st_d;
			req_q <= req_d;
			rdata_q <= rdata_d;
		end
	end
	assign xfer_rdata = rdata_q;
	// A transfer never waits in the snoop state without its snoop being issued
	a_snoop_issued: assert property (@(posedge clk) disable iff (sys_rst)
		(st_q == LSC_SNOOP && snoop_hit) |-> dsnoop.valid)
		else $error("snoop not issued while stalled");
	// An unanswered snoop keeps the transfer stalled
	a_snoop_stall: assert property (@(posedge clk) disable iff (sys_rst)
		(st_q == LSC_SNOOP && dsnoop.valid && !dsnoop_rsp.valid) |=> st_q == LSC_SNOOP)
		else $error("transfer released before snoop answer");
	a_prog_read: assert property (@(posedge clk) disable iff (sys_rst)
		(psnoop.valid) |-> req_q.write)
		else $error("program cache snooped on read");
	a_write_inval: assert property (@(posedge clk) disable iff (sys_rst)
		(dsnoop.valid && req_q.write) |-> dsnoop.invalidate)
		else $error("write snoop without invalidate");
	a_variant_keep: assert property (@(posedge clk) disable iff (sys_rst)
		(dsnoop.valid && !req_q.write && req_q.src == LSC_SRC_DMA)
		|-> dsnoop.invalidate == !KEEP_AFTER_READ)
		else $error("read snoop variant mismatch");
	// Dirty data lands in SRAM, then merge, then done on the following cycle
	a_dirty_merge: assert property (@(posedge clk) disable iff (sys_rst)
		(st_q == LSC_SNOOP && dsnoop.valid && dsnoop_rsp.valid && dsnoop_rsp.dirty)
		|-> sram_we ##1 st_q == LSC_MERGE ##1 xfer_done)
		else $error("dirty data not merged before release");
	a_write_thru: assert property (@(posedge clk) disable iff (sys_rst)
		(cpu_valid && cpu_write && cpu_in_sram && !cpu_l1_hit) |-> !cpu_l1_alloc)
		else $error("write miss allocated");
	a_single_nc: assert property (@(posedge clk) disable iff (sys_rst)
		cpu_single |-> !cpu_l1_alloc)
		else $error("non-cacheable access allocated");
	a_mar_reset: assert property (@(posedge clk)
		$fell(sys_rst) |-> ce_q == '0)
		else $error("cacheable flags not cleared");
	a_abort_idle: assert property (@(posedge clk) disable iff (sys_rst)
		xfer_abort |=> st_q == LSC_IDLE)
		else $error("refused transfer was started");
	// Host traffic always leaves the snooped line invalid
	a_host_inval: assert property (@(posedge clk) disable iff (sys_rst)
		(dsnoop.valid && req_q.src == LSC_SRC_HOST) |-> dsnoop.invalidate)
		else $error("host snoop without invalidate");
	// Outside all-SRAM mode no transfer is accepted
	a_mode_refuse: assert property (@(posedge clk) disable iff (sys_rst)
		(xfer_req.valid && xfer_ready && !all_sram) |-> xfer_abort)
		else $error("transfer accepted outside all-SRAM mode");
	// Only SRAM addresses ever reach the snoop sequencer
	a_ext_skip: assert property (@(posedge clk) disable iff (sys_rst)
		(st_q != LSC_IDLE) |-> req_q.addr < 32'(SRAM_BYTES))
		else $error("transfer outside SRAM was started");
endmodule // lsc_snooper
`default_nettype wire

// file: lsc_l1_model.sv
`timescale 1ns/1ps
`default_nettype none
// Data cache snoop responder plus the SRAM array seen by the snooper
module lsc_l1_model (
	input wire logic clk,
	input wire lsc_pkg::lsc_snoop_t dsnoop,
	output lsc_pkg::lsc_snoop_rsp_t dsnoop_rsp,
	input wire logic sram_we,
	input wire logic [31:0] sram_addr,
	input wire logic [31:0] sram_wdata,
	output logic [31:0] sram_rdata,
	input wire logic [7:0] dly,
	input wire logic dty,
	input wire logic [31:0] sdat
);
	import lsc_pkg::*;
	logic [31:0] mem [256];
	logic [7:0] cnt = 8'h0;
	logic [31:0] last = 32'h0;
	// Known fill so untouched words can be predicted
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 32'h5a5a0000 | i;
	end
	// Answer a held snoop after the chosen wait; idle data is junk
	always @(posedge clk) begin
		dsnoop_rsp <= '{1'b0, 1'b0, ~last};
		if (dsnoop.valid && !dsnoop_rsp.valid) begin
			cnt <= cnt + 8'h1;
			if (cnt >= dly) begin
				dsnoop_rsp <= '{1'b1, dty, sdat};
				last <= sdat;
				cnt <= 8'h0;
			end
		end
		if (sram_we) mem[sram_addr[9:2]] <= sram_wdata;
	end
	assign sram_rdata = mem[sram_addr[9:2]];
endmodule // lsc_l1_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lsc_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, mar_we = 1'b0, cpu_valid = 1'b0, cpu_write = 1'b0;
	logic [2:0] l2_partition_mode = 3'h0;
	logic [3:0] mar_idx = 4'h0;
	logic [31:0] mar_wdata = 32'h0, cpu_addr = 32'h0, xfer_rdata, sram_addr, sram_wdata;
	logic [31:0] sram_rdata, sdat = 32'h0, r, w, lw = 32'h0;
	lsc_xfer_t xfer_req = '0;
	lsc_snoop_t dsnoop, psnoop;
	lsc_snoop_rsp_t dsnoop_rsp;
	logic xfer_ready, xfer_done, xfer_abort, cpu_l1_alloc, cpu_single, cpu_to_sram, sram_we;
	logic dty = 1'b0, ps = 1'b0, ds = 1'b0, di = 1'b0;
	logic cpu_l1_hit = 1'b0;
	logic [31:0] xa = 32'h0;
	logic [7:0] dly = 8'h0;
	logic [35:0] q [$];
	logic [35:0] e;
	int error_cnt = 0, n_checks = 0, cyc = 0;

	always #5 clk = ~clk;

	// Design keeps the data line after a DMA read
	lsc_snooper #(.KEEP_AFTER_READ(1'b1)) u_dut (
		.clk, .sys_rst, .l2_partition_mode, .mar_we, .mar_idx, .mar_wdata, .xfer_req,
		.xfer_ready, .xfer_done, .xfer_abort, .xfer_rdata, .dsnoop, .dsnoop_rsp, .psnoop,
		.cpu_valid, .cpu_write, .cpu_addr, .cpu_l1_hit, .cpu_l1_alloc, .cpu_single,
		.cpu_to_sram, .sram_we, .sram_addr, .sram_wdata, .sram_rdata);

	lsc_l1_model u_l1 (.clk, .dsnoop, .dsnoop_rsp, .sram_we, .sram_addr, .sram_wdata,
		.sram_rdata, .dly, .dty, .sdat);

	task chk(input logic [35:0] g, input logic [35:0] x);
		n_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	task test_done;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One transfer; the note is {read, psnoop, dsnoop, invalidate, data}
	// Callers keep DMA addresses inside mapped SRAM
	task xf(input logic wr, input logic hs, input logic [31:0] a, input logic [31:0] d,
		input logic [35:0] x);
		@(negedge clk);
		xa = a;
		xfer_req <= '{1'b1, wr, hs ? LSC_SRC_HOST : LSC_SRC_DMA, a, d};
		q.push_back(x);
		@(posedge clk);
		@(negedge clk);
		xfer_req.valid <= 1'b0;
		while (!xfer_ready) @(negedge clk);
	endtask

	// Refused request: abort in the same cycle, nothing completes
	task ab(input logic [31:0] a);
		@(negedge clk);
		xfer_req <= '{1'b1, 1'b0, LSC_SRC_DMA, a, 32'h0};
		#4 chk({35'h0, xfer_abort}, 36'h1);
		@(negedge clk);
		xfer_req.valid <= 1'b0;
	endtask

	// CPU access: expect {alloc, single, to_sram}
	task cp(input logic wr, input logic [31:0] a, input logic [2:0] x);
		@(negedge clk);
		cpu_valid <= 1'b1;
		cpu_write <= wr;
		cpu_addr <= a;
		#4 chk({33'h0, cpu_l1_alloc, cpu_single, cpu_to_sram}, {33'h0, x});
		@(negedge clk);
		cpu_valid <= 1'b0;
	endtask

	// Gather snoop activity, compare each finished transfer with the oldest note
	always @(posedge clk) begin
		if (dsnoop.valid) ds <= 1'b1;
		if (dsnoop.valid && dsnoop.invalidate) di <= 1'b1;
		if (psnoop.valid) ps <= 1'b1;
		// Snoops must carry the address of the transfer in flight
		if (dsnoop.valid)
			chk({4'h0, dsnoop.addr}, {4'h0, xa});
		if (psnoop.valid)
			chk({3'h0, psnoop.invalidate, psnoop.addr}, {4'h1, xa});
		if (sram_we) lw <= sram_wdata;
		// Done is meaningless while the sequencer is still in reset
		if (xfer_done && !sys_rst) begin
			e = q.size() > 0 ? q.pop_front() : '1;
			chk({e[35], ps, ds, di, e[35] ? xfer_rdata : lw}, e);
			{ps, ds, di} <= 3'h0;
		end
	end

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			test_done;
		end
	end

	initial begin
		void'($urandom(82));
		repeat (2) @(posedge clk);
		@(negedge clk);
		sys_rst <= 1'b0;
		cp(1'b0, 32'h80000010, 3'b010);
		@(negedge clk);
		mar_we <= 1'b1;
		mar_idx <= 4'h8;
		mar_wdata <= 32'h1;
		@(negedge clk);
		mar_we <= 1'b0;
		cp(1'b0, 32'h80000010, 3'b100);
		// Second reset in mid-run must clear the flag just set
		sys_rst <= 1'b1;
		repeat (2) @(negedge clk);
		sys_rst <= 1'b0;
		cp(1'b0, 32'h80000010, 3'b010);
		cp(1'b1, 32'h100, 3'b001);
		cp(1'b0, 32'h200, 3'b101);
		// A line already present in the data cache is not allocated again
		cpu_l1_hit = 1'b1;
		cp(1'b0, 32'h200, 3'b001);
		cpu_l1_hit = 1'b0;
		r = $urandom;
		sdat = r;
		dty = 1'b1;
		dly = 8'h3;
		xf(1'b0, 1'b0, 32'h200, 32'h0, {4'b1010, r});
		dty = 1'b0;
		dly = 8'h0;
		xf(1'b0, 1'b0, 32'h200, 32'h0, {4'b1010, r});
		ab(32'h10000);
		ab(32'h80000010);
		l2_partition_mode = 3'h1;
		ab(32'h200);
		l2_partition_mode = 3'h0;
		xf(1'b0, 1'b0, 32'h300, 32'h0, {4'b1000, 32'h5a5a00c0});
		w = $urandom;
		xf(1'b1, 1'b0, 32'h200, w, {4'b0111, w});
		xf(1'b0, 1'b0, 32'h200, 32'h0, {4'b1000, w});
		cp(1'b0, 32'h200, 3'b101);
		r = $urandom;
		sdat = r;
		dty = 1'b1;
		xf(1'b0, 1'b1, 32'h200, 32'h0, {4'b1011, r});
		cp(1'b0, 32'h200, 3'b101);
		w = $urandom;
		xf(1'b1, 1'b1, 32'h200, w, {4'b0011, w});
		repeat (3) @(negedge clk);
		// Every noted transfer must have completed
		chk({4'h0, 32'(q.size())}, 36'h0);
		test_done;
	end
endmodule // tb
`default_nettype wire
